//--- logic/cph_unit.sv
// cache prefetch hint unit: address forming and cache action sequencing
//
// Contract
// - address is base plus sign-extended 16-bit offset
// - no action changes architecturally visible state
// - never raise addressing fault; faulting address moves nothing
// - invisible side actions such as writebacks allowed
// - no memory operation for uncached locations
// - memory operations use the address's access type
// - cached location fetches a line holding address
// - hint 0 fetches as for a load
// - hint 1 fetches as for a store
// - hints 4,5 streamed placement, spare retained lines
// - hints 6,7 retained placement, immune to streamed
// - hints 2-3 and 8-24 reserved, no function
// - hint 25 writes back dirty line, then invalidates
// - hint 30 miss: victim writeback, zero-fill, dirty
// - hints 26-29,31 implementation-defined prefetch
// - no translation or address exception ever
`timescale 1ns/1ns
module cph_unit
    import cph_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    // issue side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [CPH_XLEN-1:0] req_base,
    input wire logic [CPH_OFS_W-1:0] req_offset,
    input wire logic [CPH_HINT_W-1:0] req_hint,
    output logic done,
    output logic addr_exc,
    // translation lookup, answered in the cycle of the request
    output logic [CPH_XLEN-1:0] xlat_vaddr,
    output logic xlat_req,
    input wire logic xlat_fault,
    input wire logic [CPH_CCA_W-1:0] xlat_cca,
    input wire logic [CPH_PLEN-1:0] xlat_paddr,
    // cache tag lookup, answered in the cycle of the lookup
    output logic look_req,
    output logic [CPH_PLEN-1:0] look_addr,
    input wire logic look_hit,
    input wire logic look_dirty,
    input wire logic victim_valid,
    input wire logic victim_dirty,
    input wire logic [CPH_PLEN-1:0] victim_addr,
    // cache and memory operation request
    output logic mem_valid,
    input wire logic mem_ready,
    output cph_op_e mem_op,
    output logic [CPH_PLEN-1:0] mem_addr,
    output logic [CPH_CCA_W-1:0] mem_cca,
    output cph_place_e mem_place,
    input wire logic mem_done
);
    ////////////////////////////////////////////////////////////////////////
    // hint decode
    cph_hint_if hif ();
    cph_hint_decode u_dec (
        .hif(hif.dec)
    );

    logic [CPH_HINT_W-1:0] hint_q;
    assign hif.hint = hint_q;

    ////////////////////////////////////////////////////////////////////////
    // state
    cph_state_e state_q;
    cph_state_e state_d;
    logic [CPH_XLEN-1:0] vaddr_q;
    logic [CPH_CCA_W-1:0] cca_q;
    logic [CPH_PLEN-1:0] line_q;
    logic [CPH_PLEN-1:0] wb_addr_q;
    logic sent_q;
    logic take;
    logic drop;
    logic need_wb;
    logic need_main;
    logic uncached;

    function automatic logic [CPH_PLEN-1:0] line_of(input logic [CPH_PLEN-1:0] a);
        line_of = {a[CPH_PLEN-1:CPH_LINE_LSB], {CPH_LINE_LSB{1'b0}}};
    endfunction : line_of

    assign take = req_valid && (state_q == CPH_ST_IDLE);
    assign req_ready = (state_q == CPH_ST_IDLE);
    assign uncached = (xlat_cca == CPH_CCA_UNCACHED) || (xlat_cca == CPH_CCA_UNCACHED_ACC);

    // fault, uncached or inert hint: finish with no traffic
    assign drop = xlat_fault || uncached || (hif.act == CPH_ACT_NOP);

    // per-action decision taken on the tag lookup result
    always_comb begin
        need_wb = 1'b0;
        need_main = 1'b0;
        case (hif.act)
            CPH_ACT_FETCH: begin
                need_main = !look_hit;
                need_wb = !look_hit && victim_valid && victim_dirty;
            end
            CPH_ACT_WB_INV: begin
                // clean or absent lines are left alone
                need_wb = look_hit && look_dirty;
                need_main = look_hit && look_dirty;
            end
            CPH_ACT_ZERO: begin
                need_main = !look_hit;
                need_wb = !look_hit && victim_valid && victim_dirty;
            end
            default: begin
                need_wb = 1'b0;
                need_main = 1'b0;
            end
        endcase
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            CPH_ST_IDLE: begin
                if (take) begin
                    state_d = CPH_ST_XLAT;
                end
            end
            CPH_ST_XLAT: begin
                state_d = drop ? CPH_ST_FIN : CPH_ST_LOOK;
            end
            CPH_ST_LOOK: begin
                if (need_wb) begin
                    state_d = CPH_ST_WBACK;
                end else if (need_main) begin
                    state_d = CPH_ST_MAIN;
                end else begin
                    state_d = CPH_ST_FIN;
                end
            end
            CPH_ST_WBACK: begin
                if (sent_q && mem_done) begin
                    state_d = CPH_ST_MAIN;
                end
            end
            CPH_ST_MAIN: begin
                if (sent_q && mem_done) begin
                    state_d = CPH_ST_FIN;
                end
            end
            CPH_ST_FIN: begin
                state_d = CPH_ST_IDLE;
            end
            default: begin
                state_d = CPH_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= CPH_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request capture and address forming
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vaddr_q <= '0;
            hint_q <= '0;
        end else if (take) begin
            vaddr_q <= req_base + {{(CPH_XLEN-CPH_OFS_W){req_offset[CPH_OFS_W-1]}}, req_offset};
            hint_q <= req_hint;
        end
    end

    assign xlat_vaddr = vaddr_q;
    assign xlat_req = (state_q == CPH_ST_XLAT);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cca_q <= '0;
            line_q <= '0;
        end else if (state_q == CPH_ST_XLAT) begin
            cca_q <= xlat_cca;
            line_q <= line_of(xlat_paddr);
        end
    end

    assign look_req = (state_q == CPH_ST_LOOK);
    assign look_addr = line_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_addr_q <= '0;
        end else if (state_q == CPH_ST_LOOK) begin
            // the addressed line itself for a nudge, else the chosen victim
            wb_addr_q <= (hif.act == CPH_ACT_WB_INV) ? line_q : line_of(victim_addr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory operation issue; one outstanding at a time
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sent_q <= 1'b0;
        end else if (mem_valid && mem_ready) begin
            sent_q <= 1'b1;
        end else if (sent_q && mem_done) begin
            sent_q <= 1'b0;
        end
    end

    assign mem_valid = ((state_q == CPH_ST_WBACK) || (state_q == CPH_ST_MAIN)) && !sent_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_op <= CPH_OP_FILL_SHARED;
            mem_addr <= '0;
            mem_cca <= '0;
            mem_place <= CPH_PLACE_NORMAL;
        end else if (state_d == CPH_ST_WBACK && state_q != CPH_ST_WBACK) begin
            mem_op <= CPH_OP_WRITEBACK;
            mem_addr <= wb_addr_q;
            mem_cca <= cca_q;
            mem_place <= CPH_PLACE_NORMAL;
            if (state_q == CPH_ST_LOOK) begin
                mem_addr <= (hif.act == CPH_ACT_WB_INV) ? line_q : line_of(victim_addr);
            end
        end else if (state_d == CPH_ST_MAIN && state_q != CPH_ST_MAIN) begin
            mem_addr <= line_q;
            mem_cca <= cca_q;
            mem_place <= hif.place;
            case (hif.act)
                CPH_ACT_WB_INV: begin
                    // invalidate only after the writeback has completed
                    mem_op <= CPH_OP_INVALIDATE;
                end
                CPH_ACT_ZERO: begin
                    mem_op <= CPH_OP_ZERO_ALLOC;
                end
                default: begin
                    mem_op <= hif.is_store ? CPH_OP_FILL_EXCL : CPH_OP_FILL_SHARED;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion; the prefetch never writes a register nor traps
    assign done = (state_q == CPH_ST_FIN);
    assign addr_exc = 1'b0;
endmodule : cph_unit

//--- logic/cph_pkg.sv
// shared constants and types for the cache prefetch hint unit
package cph_pkg;
    localparam int unsigned CPH_XLEN = 64;
    localparam int unsigned CPH_PLEN = 40;
    localparam int unsigned CPH_OFS_W = 16;
    localparam int unsigned CPH_HINT_W = 5;
    localparam int unsigned CPH_CCA_W = 3;
    localparam int unsigned CPH_LINE_LSB = 5;

    // cacheability attribute codes as returned by translation
    localparam logic [2:0] CPH_CCA_UNCACHED = 3'h2;
    localparam logic [2:0] CPH_CCA_UNCACHED_ACC = 3'h7;

    // hint encodings
    localparam logic [4:0] CPH_H_LOAD = 5'h00;
    localparam logic [4:0] CPH_H_STORE = 5'h01;
    localparam logic [4:0] CPH_H_LOAD_STREAM = 5'h04;
    localparam logic [4:0] CPH_H_STORE_STREAM = 5'h05;
    localparam logic [4:0] CPH_H_LOAD_RETAIN = 5'h06;
    localparam logic [4:0] CPH_H_STORE_RETAIN = 5'h07;
    localparam logic [4:0] CPH_H_RSV_LO_FIRST = 5'h02;
    localparam logic [4:0] CPH_H_RSV_LO_LAST = 5'h03;
    localparam logic [4:0] CPH_H_RSV_HI_FIRST = 5'h08;
    localparam logic [4:0] CPH_H_RSV_HI_LAST = 5'h18;
    localparam logic [4:0] CPH_H_WB_INV = 5'h19;
    localparam logic [4:0] CPH_H_IMPL_FIRST = 5'h1a;
    localparam logic [4:0] CPH_H_IMPL_LAST = 5'h1d;
    localparam logic [4:0] CPH_H_ZERO_ALLOC = 5'h1e;
    localparam logic [4:0] CPH_H_IMPL_TOP = 5'h1f;

    typedef enum logic [1:0] {
        CPH_ACT_NOP = 2'h0,
        CPH_ACT_FETCH = 2'h1,
        CPH_ACT_WB_INV = 2'h2,
        CPH_ACT_ZERO = 2'h3
    } cph_act_e;

    typedef enum logic [1:0] {
        CPH_PLACE_NORMAL = 2'h0,
        CPH_PLACE_STREAM = 2'h1,
        CPH_PLACE_RETAIN = 2'h2
    } cph_place_e;

    typedef enum logic [2:0] {
        CPH_OP_FILL_SHARED = 3'h0,
        CPH_OP_FILL_EXCL = 3'h1,
        CPH_OP_WRITEBACK = 3'h2,
        CPH_OP_INVALIDATE = 3'h3,
        CPH_OP_ZERO_ALLOC = 3'h4
    } cph_op_e;

    typedef enum logic [5:0] {
        CPH_ST_IDLE = 6'b000001,
        CPH_ST_XLAT = 6'b000010,
        CPH_ST_LOOK = 6'b000100,
        CPH_ST_WBACK = 6'b001000,
        CPH_ST_MAIN = 6'b010000,
        CPH_ST_FIN = 6'b100000
    } cph_state_e;
endpackage : cph_pkg

//--- logic/cph_hint_if.sv
// carrier between the hint decoder and the sequencer
`timescale 1ns/1ns
interface cph_hint_if;
    import cph_pkg::*;
    logic [4:0] hint;
    cph_act_e act;
    logic is_store;
    cph_place_e place;
    modport dec (input hint, output act, output is_store, output place);
    modport use_side (output hint, input act, input is_store, input place);
endinterface : cph_hint_if

//--- logic/cph_hint_decode.sv
// hint code decoder: action class, intent and placement
`timescale 1ns/1ns
module cph_hint_decode
    import cph_pkg::*;
(
    cph_hint_if.dec hif
);
    function automatic logic in_range(input logic [4:0] h, input logic [4:0] lo, input logic [4:0] hi);
        in_range = (h >= lo) && (h <= hi);
    endfunction : in_range

    function automatic logic impl_dep(input logic [4:0] h);
        impl_dep = in_range(h, CPH_H_IMPL_FIRST, CPH_H_IMPL_LAST) || (h == CPH_H_IMPL_TOP);
    endfunction : impl_dep

    always_comb begin
        hif.act = CPH_ACT_NOP;
        hif.is_store = 1'b0;
        hif.place = CPH_PLACE_NORMAL;
        case (hif.hint)
            CPH_H_LOAD: begin
                hif.act = CPH_ACT_FETCH;
            end
            CPH_H_STORE: begin
                hif.act = CPH_ACT_FETCH;
                hif.is_store = 1'b1;
            end
            CPH_H_LOAD_STREAM, CPH_H_STORE_STREAM: begin
                hif.act = CPH_ACT_FETCH;
                hif.is_store = hif.hint[0];
                hif.place = CPH_PLACE_STREAM;
            end
            CPH_H_LOAD_RETAIN, CPH_H_STORE_RETAIN: begin
                hif.act = CPH_ACT_FETCH;
                hif.is_store = hif.hint[0];
                hif.place = CPH_PLACE_RETAIN;
            end
            CPH_H_WB_INV: begin
                hif.act = CPH_ACT_WB_INV;
            end
            CPH_H_ZERO_ALLOC: begin
                hif.act = CPH_ACT_ZERO;
                hif.is_store = 1'b1;
            end
            default: begin
                // reserved codes stay inert; free codes act as a plain load fetch
                if (impl_dep(hif.hint)) begin
                    hif.act = CPH_ACT_FETCH;
                end else begin
                    hif.act = CPH_ACT_NOP;
                end
            end
        endcase
    end
endmodule : cph_hint_decode

//--- tb/cph_checker.sv
// concurrent checks on the prefetch hint unit ports
`timescale 1ns/1ns
module cph_checker
    import cph_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [CPH_XLEN-1:0] req_base,
    input wire logic [CPH_OFS_W-1:0] req_offset,
    input wire logic [CPH_HINT_W-1:0] req_hint,
    input wire logic done,
    input wire logic addr_exc,
    input wire logic [CPH_XLEN-1:0] xlat_vaddr,
    input wire logic xlat_req,
    input wire logic xlat_fault,
    input wire logic [CPH_CCA_W-1:0] xlat_cca,
    input wire logic [CPH_PLEN-1:0] xlat_paddr,
    input wire logic look_req,
    input wire logic [CPH_PLEN-1:0] look_addr,
    input wire logic look_hit,
    input wire logic look_dirty,
    input wire logic mem_valid,
    input wire logic mem_ready,
    input wire cph_op_e mem_op,
    input wire logic [CPH_PLEN-1:0] mem_addr,
    input wire logic [CPH_CCA_W-1:0] mem_cca,
    input wire cph_place_e mem_place
);
    logic [CPH_XLEN-1:0] ea_q;
    logic [4:0] hint_q;
    logic [CPH_CCA_W-1:0] cca_q;
    logic [CPH_PLEN-1:0] pa_q;
    logic st_w;
    logic quiet_w;
    cph_place_e pl_w;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ea_q <= '0;
            hint_q <= '0;
        end else if (req_valid && req_ready) begin
            ea_q <= req_base + {{48{req_offset[15]}}, req_offset};
            hint_q <= req_hint;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cca_q <= '0;
            pa_q <= '0;
        end else if (xlat_req) begin
            cca_q <= xlat_cca;
            pa_q <= xlat_paddr;
        end
    end
    assign st_w = hint_q inside {CPH_H_STORE, CPH_H_STORE_STREAM, CPH_H_STORE_RETAIN};
    assign pl_w = hint_q inside {CPH_H_LOAD_STREAM, CPH_H_STORE_STREAM} ? CPH_PLACE_STREAM :
        hint_q inside {CPH_H_LOAD_RETAIN, CPH_H_STORE_RETAIN} ? CPH_PLACE_RETAIN : CPH_PLACE_NORMAL;
    assign quiet_w = xlat_fault || (xlat_cca inside {CPH_CCA_UNCACHED, CPH_CCA_UNCACHED_ACC}) ||
        (hint_q inside {[CPH_H_RSV_LO_FIRST:CPH_H_RSV_LO_LAST], [CPH_H_RSV_HI_FIRST:CPH_H_RSV_HI_LAST]});
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_quiet_end;
        done && !look_req && !mem_valid;
    endsequence
    a_no_exc: assert property (addr_exc == 1'b0)
        else $error("exception flag raised");
    a_addr_form: assert property (s_take |=> xlat_req && xlat_vaddr == ea_q)
        else $error("effective address wrong");
    a_quiet_nop: assert property (xlat_req && quiet_w |=> s_quiet_end)
        else $error("quiet request did work");
    a_line_addr: assert property (look_req |-> look_addr == {pa_q[39:5], 5'h0})
        else $error("lookup line address wrong");
    a_acc_type: assert property (mem_valid && mem_op != CPH_OP_WRITEBACK |-> mem_cca == cca_q)
        else $error("access type not carried");
    a_fill_intent: assert property (mem_valid && mem_op inside {CPH_OP_FILL_SHARED, CPH_OP_FILL_EXCL} |->
        mem_op == (st_w ? CPH_OP_FILL_EXCL : CPH_OP_FILL_SHARED) && mem_place == pl_w)
        else $error("fill kind or placement wrong");
    a_hit_idle: assert property (look_req && look_hit && !(hint_q == CPH_H_WB_INV && look_dirty) |=>
        done && !mem_valid)
        else $error("hit caused memory work");
    a_hold_req: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_op) && $stable(mem_addr))
        else $error("memory request dropped or changed");
    a_done_once: assert property (done |=> !done && req_ready)
        else $error("done not a single pulse");
    a_wbinv_only: assert property (mem_valid && mem_op == CPH_OP_INVALIDATE |-> hint_q == CPH_H_WB_INV)
        else $error("invalidate from wrong hint");
endmodule : cph_checker

//--- tb/cph_mem_model.sv
// translation, tag lookup and memory side model
`timescale 1ns/1ns
module cph_mem_model
    import cph_pkg::*;
#(
    parameter logic [39:0] VICTIM_LINE = 40'h12_3456_7000
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic c_fault,
    input wire logic [2:0] c_cca,
    input wire logic c_hit,
    input wire logic c_dirty,
    input wire logic c_vv,
    input wire logic c_vd,
    input wire logic xlat_req,
    input wire logic [63:0] xlat_vaddr,
    output logic xlat_fault,
    output logic [2:0] xlat_cca,
    output logic [39:0] xlat_paddr,
    input wire logic look_req,
    output logic look_hit,
    output logic look_dirty,
    output logic victim_valid,
    output logic victim_dirty,
    output logic [39:0] victim_addr,
    input wire logic mem_valid,
    output logic mem_ready,
    output logic mem_done
);
    logic tg_q, w_q, a_q, b_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {tg_q, w_q, a_q, b_q} <= '0;
        end else begin
            tg_q <= !tg_q;
            w_q <= mem_valid && !mem_ready;
            a_q <= mem_valid && mem_ready;
            b_q <= a_q;
        end
    end
    // unanswered lines toggle so stale values cannot pass
    assign xlat_fault = xlat_req ? c_fault : tg_q;
    assign xlat_cca = xlat_req ? c_cca : {3{tg_q}};
    assign xlat_paddr = xlat_req ? xlat_vaddr[39:0] : {40{tg_q}};
    assign look_hit = look_req ? c_hit : tg_q;
    assign look_dirty = look_req ? c_dirty : tg_q;
    assign victim_valid = look_req ? c_vv : tg_q;
    assign victim_dirty = look_req ? c_vd : tg_q;
    assign victim_addr = look_req ? VICTIM_LINE : {40{tg_q}};
    assign mem_ready = mem_valid && (!slow || w_q);
    assign mem_done = slow ? b_q : a_q;
endmodule : cph_mem_model

//--- tb/testbench.sv
// self-checking testbench for the prefetch hint unit
`timescale 1ns/1ns
module testbench;
    import cph_pkg::*;
    localparam logic [39:0] VIC = 40'h12_3456_7000;
    logic clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, slow = 1'b0;
    logic c_fault = 1'b0, c_hit = 1'b0, c_dirty = 1'b0, c_vv = 1'b0, c_vd = 1'b0;
    logic [2:0] c_cca = 3'h3;
    logic [63:0] req_base = 64'h0000_0001_2345_6789;
    logic [15:0] req_offset = '0;
    logic [4:0] req_hint = '0;
    wire req_ready, done, addr_exc, xlat_req, xlat_fault, look_req, look_hit, look_dirty;
    wire victim_valid, victim_dirty, mem_valid, mem_ready, mem_done;
    wire [63:0] xlat_vaddr;
    wire [2:0] xlat_cca, mem_cca;
    wire [39:0] xlat_paddr, look_addr, victim_addr, mem_addr;
    cph_op_e mem_op;
    cph_place_e mem_place;
    logic [63:0] log [$];
    int n_errors = 0, compares = 0, cyc = 0;
    cph_unit dut (.*);
    cph_mem_model #(.VICTIM_LINE(VIC)) mdl (.*);
    always #20 clk = ~clk;
    always @(posedge clk) if (mem_valid && mem_ready) log.push_back({18'h0, mem_op, mem_op == CPH_OP_WRITEBACK ? 3'h0 : mem_cca, mem_addr});
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    function automatic logic [63:0] ex(input logic [2:0] op, input logic [39:0] a);
        return {18'h0, op, op == CPH_OP_WRITEBACK ? 3'h0 : c_cca, a};
    endfunction : ex
    function automatic logic [39:0] ln();
        return 40'(req_base + {{48{req_offset[15]}}, req_offset}) & ~40'h1f;
    endfunction : ln
    // one request: cf is {slow, fault, hit, dirty, victim valid, victim dirty}
    task automatic run(input logic [4:0] h, input logic [15:0] o, input logic [2:0] cc, input logic [5:0] cf, input int n);
        int k;
        @(negedge clk);
        {slow, c_fault, c_hit, c_dirty, c_vv, c_vd} = cf;
        c_cca = cc;
        req_hint = h;
        req_offset = o;
        req_valid = 1'b1;
        log.delete();
        @(negedge clk);
        req_valid = 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++) @(negedge clk);
        chk("done", 64'h1, 64'(k < 40));
        chk("addr_exc", 64'h0, 64'(addr_exc));
        chk("vaddr", req_base + {{48{o[15]}}, o}, xlat_vaddr);
        chk("n_ops", 64'(n), 64'(log.size()));
        @(negedge clk);
    endtask : run
    task automatic t_fetch();
        int hl [11] = '{0, 1, 4, 5, 6, 7, 26, 27, 28, 29, 31};
        for (int i = 0; i < 11; i++) begin
            run(5'(hl[i]), i[0] ? 16'h8001 : 16'h0105, 3'h3, {i[0], 5'b0}, 1);
            chk("fill", ex(hl[i] inside {1, 5, 7} ? CPH_OP_FILL_EXCL : CPH_OP_FILL_SHARED, ln()), log[0]);
        end
        run(5'h00, 16'hfff0, 3'h4, 6'b000011, 2);
        chk("wb_victim", ex(CPH_OP_WRITEBACK, VIC), log[0]);
        chk("fill_after", ex(CPH_OP_FILL_SHARED, ln()), log[1]);
        $display("test fetch finished");
    endtask : t_fetch
    task automatic t_quiet();
        for (int h = 2; h < 25; h++) if (h < 4 || h > 7) run(5'(h), 16'h0040, 3'h3, 6'b000011, 0);
        run(5'h00, 16'h0020, 3'h3, 6'b010011, 0);
        run(5'h01, 16'h0020, CPH_CCA_UNCACHED, 6'b000011, 0);
        run(5'h06, 16'h0020, CPH_CCA_UNCACHED_ACC, 6'b000011, 0);
        run(5'h07, 16'h0020, 3'h3, 6'b001100, 0);
        $display("test quiet finished");
    endtask : t_quiet
    task automatic t_wbinv();
        run(CPH_H_WB_INV, 16'h7ffc, 3'h3, 6'b101100, 2);
        chk("wb_line", ex(CPH_OP_WRITEBACK, ln()), log[0]);
        chk("inval", ex(CPH_OP_INVALIDATE, ln()), log[1]);
        run(CPH_H_WB_INV, 16'h7ffc, 3'h3, 6'b001000, 0);
        // a miss must leave even a dirty victim alone
        run(CPH_H_WB_INV, 16'h7ffc, 3'h3, 6'b000011, 0);
        $display("test writeback invalidate finished");
    endtask : t_wbinv
    task automatic t_zero();
        run(CPH_H_ZERO_ALLOC, 16'h8000, 3'h5, 6'b100011, 2);
        chk("zero_wb", ex(CPH_OP_WRITEBACK, VIC), log[0]);
        chk("zero_fill", ex(CPH_OP_ZERO_ALLOC, ln()), log[1]);
        run(CPH_H_ZERO_ALLOC, 16'h8000, 3'h5, 6'b001100, 0);
        $display("test zero allocate finished");
    endtask : t_zero
    // reset while a writeback waits for acceptance, then a clean request
    task automatic t_reset();
        @(negedge clk);
        {slow, c_fault, c_hit, c_dirty, c_vv, c_vd} = 6'b100011;
        req_hint = CPH_H_STORE;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b0;
        @(negedge clk);
        chk("rst_state", 64'h10, 64'({req_ready, done, mem_valid, xlat_req, look_req}));
        @(negedge clk);
        rstn = 1'b1;
        run(5'h01, 16'h0040, 3'h3, 6'b000000, 1);
        chk("rst_fill", ex(CPH_OP_FILL_EXCL, ln()), log[0]);
        $display("test reset finished");
    endtask : t_reset
    task automatic test_done();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        t_fetch();
        t_quiet();
        t_wbinv();
        t_zero();
        t_reset();
        test_done();
    end
endmodule : testbench
bind cph_unit cph_checker chk_i (.*);
